// file: rtl/eecs_regs.svh
// Register offsets, command codes and fixed values of the EEPROM command sequencer
`ifndef EECS_REGS_SVH
`define EECS_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define EECS_OFF_ADDR_LOW 12'h000
`define EECS_OFF_ADDR_HIGH 12'h004
`define EECS_OFF_DATA_LOW 12'h008
`define EECS_OFF_COMMAND 12'h00C
`define EECS_OFF_CONTROL_A 12'h010
`define EECS_OFF_STATUS 12'h014
`define EECS_OFF_PROTECT 12'h018

// ****************************************************************
// Fields and values
// ****************************************************************
`define EECS_CONTROL_A_EXECUTE_BIT 0
`define EECS_STATUS_BUSY_BIT 7
`define EECS_STATUS_ENABLED_BIT 0
`define EECS_PROTECT_UNLOCK 8'hD8
`define EECS_PROTECT_WINDOW 4'h4
`define EECS_DBG_RESET_VALUE 8'h59

// ****************************************************************
// Command codes
// ****************************************************************
`define EECS_CMD_LOAD_BUFFER 7'h33
`define EECS_CMD_ERASE_BUFFER 7'h36
`define EECS_CMD_ERASE_PAGE 7'h32
`define EECS_CMD_WRITE_PAGE 7'h34
`define EECS_CMD_ERASE_WRITE_PAGE 7'h35
`define EECS_CMD_ERASE_ALL 7'h30
`define EECS_CMD_READ 7'h06

// ****************************************************************
// Debug linear address map
// ****************************************************************
`define EECS_FLASH_BASE 25'h080_0000
`define EECS_EEPROM_BASE 25'h08C_0000
`define EECS_DATA_BASE 25'h100_0000

`endif

// file: rtl/eecs_pkg.sv
// Types shared by the EEPROM command sequencer
`default_nettype none
package eecs_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ERASE = 3'b001,
		ST_WRITE = 3'b010,
		ST_ALL = 3'b011,
		ST_WAIT = 3'b100
	} eecs_state_t;

	typedef enum logic [1:0] {
		RG_NONE = 2'b00,
		RG_FLASH = 2'b01,
		RG_EEPROM = 2'b10,
		RG_DATA = 2'b11
	} eecs_region_t;
endpackage : eecs_pkg
`default_nettype wire

// file: rtl/eecs_sequencer.sv
// EEPROM command sequencer with APB registers and debug memory port
`include "eecs_regs.svh"
`default_nettype none
module eecs_sequencer #(
	parameter int PAGE_BYTES = 32,
	parameter int PAGE_COUNT = 32,
	parameter int OP_CYCLES = 16,
	parameter logic [7:0] ENABLE_CYCLES = 8'h08,
	// Access key value is arbitrary
	parameter logic [63:0] DBG_KEY = 64'h1234_5678_9ABC_DEF0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dbgResetWrite,
	input wire logic [7:0] dbgResetData,
	input wire logic dbgKeyWrite,
	input wire logic [63:0] dbgKey,
	output logic memoryInterfaceEnabled,
	input wire logic dbgValid,
	input wire logic dbgWrite,
	input wire logic [24:0] dbgAddr,
	input wire logic [7:0] dbgWdata,
	output logic dbgReady,
	output logic [7:0] dbgRdata
);
	localparam int BW = $clog2(PAGE_BYTES);
	localparam int AW = $clog2(PAGE_BYTES * PAGE_COUNT);
	localparam int DEPTH = PAGE_BYTES * PAGE_COUNT;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		eecs_pkg::eecs_state_t state;
		logic [15:0] addr;
		logic [7:0] data;
		logic [6:0] cmd;
		logic [AW-1:0] idx;
		logic [15:0] timer;
		logic [3:0] unlock;
		logic [PAGE_BYTES-1:0] tags;
		logic thenWrite;
		logic armed;
		logic enabled;
		logic [7:0] enCount;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic dbgReady;
		logic [7:0] dbgRdata;
	} eecs_regs_t;

	eecs_regs_t s;
	eecs_regs_t next_s;

	// Memories carry no reset; only tags decide what an operation touches
	logic [7:0] eeprom [DEPTH];
	logic [7:0] pageBuf [PAGE_BYTES];

	logic memWe;
	logic [AW-1:0] memAddr;
	logic [7:0] memWdata;
	logic bufWe;
	logic [BW-1:0] bufIdx;
	logic [7:0] bufWdata;
	logic busy;
	logic startValid;
	logic [6:0] startCmd;
	logic [AW-1:0] startAddr;
	logic apbWrite;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic eecs_pkg::eecs_region_t regionOf(input logic [24:0] a);
		if (a >= `EECS_DATA_BASE) begin
			regionOf = eecs_pkg::RG_DATA;
		end else if (a >= `EECS_EEPROM_BASE && a < `EECS_EEPROM_BASE + 25'(DEPTH)) begin
			regionOf = eecs_pkg::RG_EEPROM;
		end else if (a >= `EECS_FLASH_BASE && a < `EECS_EEPROM_BASE) begin
			regionOf = eecs_pkg::RG_FLASH;
		end else begin
			regionOf = eecs_pkg::RG_NONE;
		end
	endfunction : regionOf

	function automatic logic [AW-1:0] pageBase(input logic [AW-1:0] a);
		pageBase = a & ~AW'(PAGE_BYTES - 1);
	endfunction : pageBase

	// Buffer load is decoded on both the register path and the debug path
	function automatic logic isLoad(input logic [6:0] c);
		isLoad = (c == `EECS_CMD_LOAD_BUFFER);
	endfunction : isLoad

	// Page commands launch from a debug write as well as from the execute bit
	function automatic logic isPageCmd(input logic [6:0] c);
		isPageCmd = (c == `EECS_CMD_ERASE_PAGE) || (c == `EECS_CMD_WRITE_PAGE) ||
			(c == `EECS_CMD_ERASE_WRITE_PAGE);
	endfunction : isPageCmd

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_s = s;
		memWe = 1'b0;
		memAddr = s.idx;
		memWdata = 8'hFF;
		bufWe = 1'b0;
		bufIdx = s.addr[BW-1:0];
		bufWdata = s.data;
		startValid = 1'b0;
		startCmd = s.cmd;
		startAddr = s.addr[AW-1:0];
		busy = (s.state != eecs_pkg::ST_IDLE);
		apbWrite = psel && penable && s.pready && pwrite;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.dbgReady = 1'b0;
		if (s.unlock != 4'h0) begin
			next_s.unlock = s.unlock - 4'h1;
		end

		// APB setup cycle: answer is ready in the following access cycle
		if (psel && !penable) begin
			next_s.pready = 1'b1;
			next_s.prdata = 32'h0000_0000;
			unique case (paddr)
				`EECS_OFF_ADDR_LOW: next_s.prdata[7:0] = s.addr[7:0];
				`EECS_OFF_ADDR_HIGH: next_s.prdata[7:0] = s.addr[15:8];
				`EECS_OFF_DATA_LOW: next_s.prdata[7:0] = s.data;
				`EECS_OFF_COMMAND: next_s.prdata[6:0] = s.cmd;
				`EECS_OFF_CONTROL_A: next_s.prdata = 32'h0000_0000;
				`EECS_OFF_STATUS: begin
					next_s.prdata[`EECS_STATUS_BUSY_BIT] = busy;
					next_s.prdata[`EECS_STATUS_ENABLED_BIT] = s.enabled;
				end
				`EECS_OFF_PROTECT: next_s.prdata[0] = (s.unlock != 4'h0);
				default: next_s.pslverr = 1'b1;
			endcase
		end

		// APB write takes effect only at the completing edge
		if (apbWrite) begin
			unique case (paddr)
				`EECS_OFF_ADDR_LOW: if (!busy) next_s.addr[7:0] = pwdata[7:0];
				`EECS_OFF_ADDR_HIGH: if (!busy) next_s.addr[15:8] = pwdata[7:0];
				`EECS_OFF_DATA_LOW: begin
					if (!busy) begin
						next_s.data = pwdata[7:0];
						if (isLoad(s.cmd)) begin
							bufWe = 1'b1;
							bufIdx = s.addr[BW-1:0];
							bufWdata = pwdata[7:0];
							next_s.tags[s.addr[BW-1:0]] = 1'b1;
						end
					end
				end
				`EECS_OFF_COMMAND: if (!busy) next_s.cmd = pwdata[6:0];
				`EECS_OFF_CONTROL_A: begin
					// Unprotected when the debug port owns the memory interface
					if (pwdata[`EECS_CONTROL_A_EXECUTE_BIT] && !busy && (s.unlock != 4'h0 || s.enabled)) begin
						startValid = 1'b1;
						next_s.unlock = 4'h0;
					end
				end
				`EECS_OFF_PROTECT: begin
					if (pwdata[7:0] == `EECS_PROTECT_UNLOCK) begin
						next_s.unlock = `EECS_PROTECT_WINDOW;
					end
				end
				default: begin
				end
			endcase
		end

		// Debug memory access; the programmer never needs the address registers
		if (s.enabled && dbgValid && !s.dbgReady) begin
			if (regionOf(dbgAddr) == eecs_pkg::RG_EEPROM) begin
				if (!busy) begin
					next_s.dbgReady = 1'b1;
					next_s.dbgRdata = 8'h00;
					if (dbgWrite) begin
						if (isLoad(s.cmd)) begin
							bufWe = 1'b1;
							bufIdx = dbgAddr[BW-1:0];
							bufWdata = dbgWdata;
							next_s.tags[dbgAddr[BW-1:0]] = 1'b1;
						end else if (isPageCmd(s.cmd)) begin
							startValid = 1'b1;
							startAddr = dbgAddr[AW-1:0];
						end
					end else if (s.cmd == `EECS_CMD_READ) begin
						next_s.dbgRdata = eeprom[dbgAddr[AW-1:0]];
					end
				end
			end else begin
				next_s.dbgReady = 1'b1;
				next_s.dbgRdata = 8'h00;
			end
		end

		// Command launch
		if (startValid) begin
			unique case (startCmd)
				`EECS_CMD_ERASE_BUFFER: begin
					next_s.tags = '0;
					next_s.state = eecs_pkg::ST_WAIT;
					next_s.timer = 16'(OP_CYCLES);
				end
				`EECS_CMD_ERASE_PAGE: begin
					next_s.state = eecs_pkg::ST_ERASE;
					next_s.idx = pageBase(startAddr);
					next_s.thenWrite = 1'b0;
				end
				`EECS_CMD_WRITE_PAGE: begin
					next_s.state = eecs_pkg::ST_WRITE;
					next_s.idx = pageBase(startAddr);
				end
				`EECS_CMD_ERASE_WRITE_PAGE: begin
					next_s.state = eecs_pkg::ST_ERASE;
					next_s.idx = pageBase(startAddr);
					next_s.thenWrite = 1'b1;
				end
				`EECS_CMD_ERASE_ALL: begin
					next_s.state = eecs_pkg::ST_ALL;
					next_s.idx = '0;
				end
				`EECS_CMD_READ: begin
					next_s.data = eeprom[startAddr];
				end
				default: begin
				end
			endcase
		end

		// Operation sequencer, one byte location per cycle
		unique case (s.state)
			eecs_pkg::ST_IDLE: begin
			end
			eecs_pkg::ST_ERASE: begin
				memWe = s.tags[s.idx[BW-1:0]];
				next_s.idx = s.idx + AW'(1);
				if (s.idx[BW-1:0] == '1) begin
					if (s.thenWrite) begin
						next_s.state = eecs_pkg::ST_WRITE;
						next_s.idx = pageBase(s.idx);
					end else begin
						next_s.state = eecs_pkg::ST_WAIT;
						next_s.timer = 16'(OP_CYCLES);
					end
				end
			end
			eecs_pkg::ST_WRITE: begin
				memWe = s.tags[s.idx[BW-1:0]];
				memWdata = pageBuf[s.idx[BW-1:0]];
				next_s.idx = s.idx + AW'(1);
				if (s.idx[BW-1:0] == '1) begin
					next_s.tags = '0;
					next_s.state = eecs_pkg::ST_WAIT;
					next_s.timer = 16'(OP_CYCLES);
				end
			end
			eecs_pkg::ST_ALL: begin
				// Slow walk over every location, but a single write port serves all operations
				memWe = s.tags[s.idx[BW-1:0]];
				next_s.idx = s.idx + AW'(1);
				if (s.idx == '1) begin
					next_s.state = eecs_pkg::ST_WAIT;
					next_s.timer = 16'(OP_CYCLES);
				end
			end
			eecs_pkg::ST_WAIT: begin
				// Models cell programming time; busy stays up until it expires
				if (s.timer <= 16'h0001) begin
					next_s.state = eecs_pkg::ST_IDLE;
					next_s.timer = 16'h0000;
				end else begin
					next_s.timer = s.timer - 16'h0001;
				end
			end
			default: next_s.state = eecs_pkg::ST_IDLE;
		endcase

		// Debug enable sequence
		if (dbgResetWrite) begin
			if (dbgResetData == `EECS_DBG_RESET_VALUE) begin
				next_s.armed = 1'b1;
			end else begin
				next_s.armed = 1'b0;
				next_s.enabled = 1'b0;
				next_s.enCount = 8'h00;
			end
		end else if (dbgKeyWrite && s.armed && dbgKey == DBG_KEY) begin
			next_s.enCount = (ENABLE_CYCLES == 8'h00) ? 8'h01 : ENABLE_CYCLES;
		end else if (s.enCount != 8'h00) begin
			next_s.enCount = s.enCount - 8'h01;
			if (s.enCount == 8'h01) begin
				next_s.enabled = 1'b1;
			end
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// Memories
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (memWe) begin
			eeprom[memAddr] <= memWdata;
		end
		if (bufWe) begin
			pageBuf[bufIdx] <= bufWdata;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign memoryInterfaceEnabled = s.enabled;
	assign dbgReady = s.dbgReady;
	assign dbgRdata = s.dbgRdata;
endmodule : eecs_sequencer
`default_nettype wire

// file: dv/eecs_seq_props.sv
// Port checker for the EEPROM command sequencer
`default_nettype none
module eecs_seq_props #(parameter logic [63:0] DBG_KEY = 64'h0000_0000_0000_0000) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dbgResetWrite,
	input wire logic [7:0] dbgResetData,
	input wire logic dbgKeyWrite,
	input wire logic [63:0] dbgKey,
	input wire logic memoryInterfaceEnabled,
	input wire logic dbgValid,
	input wire logic dbgReady
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	logic armed;
	// Tracks the reset register so the key is judged in context
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) armed <= 1'b0;
		else if (dbgResetWrite) armed <= (dbgResetData == 8'h59);
	end
	apb_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
	apb_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error");
	dbg_pulse_a: assert property (dbgReady |=> !dbgReady) else $error("dbgReady longer than one cycle");
	dbg_cause_a: assert property (dbgReady |-> $past(dbgValid) && $past(memoryInterfaceEnabled))
		else $error("debug answer without enabled request");
	key_enable_a: assert property (dbgKeyWrite && dbgKey == DBG_KEY && armed |-> ##[1:10] memoryInterfaceEnabled)
		else $error("interface not enabled after key");
	enable_cause_a: assert property ($rose(memoryInterfaceEnabled) |-> armed) else $error("enabled unarmed");
	enable_delay_a: assert property (dbgKeyWrite && !memoryInterfaceEnabled |=> !memoryInterfaceEnabled [*4])
		else $error("interface enabled too early");
endmodule : eecs_seq_props
`default_nettype wire

// file: dv/eecs_dbg_model.sv
// Debug programmer model driving the memory port
`default_nettype none
module eecs_dbg_model #(parameter logic [63:0] KEY = 64'h0000_0000_0000_0000) (
	input wire logic clk,
	input wire logic dbgReady,
	input wire logic [7:0] dbgRdata,
	output logic dbgResetWrite,
	output logic [7:0] dbgResetData,
	output logic dbgKeyWrite,
	output logic [63:0] dbgKey,
	output logic dbgValid,
	output logic dbgWrite,
	output logic [24:0] dbgAddr,
	output logic [7:0] dbgWdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{dbgResetWrite, dbgKeyWrite, dbgValid, dbgWrite} = 4'h0;
		{dbgResetData, dbgKey, dbgAddr, dbgWdata} = '0;
	end
	// Reset value, then key; caller polls the enable bit
	task automatic enable();
		@(posedge clk);
		dbgResetWrite <= 1'b1;
		dbgResetData <= 8'h59;
		@(posedge clk);
		dbgResetWrite <= 1'b0;
		dbgKeyWrite <= 1'b1;
		dbgKey <= KEY;
		@(posedge clk);
		dbgKeyWrite <= 1'b0;
		dbgKey <= ~KEY;
	endtask : enable
	// Full mapped byte address; request held until answered
	task automatic access(input logic w, input logic [24:0] a, input logic [7:0] d, output logic [7:0] r);
		@(posedge clk);
		dbgValid <= 1'b1;
		dbgWrite <= w;
		dbgAddr <= a;
		dbgWdata <= d;
		do @(posedge clk); while (dbgReady !== 1'b1);
		r = dbgRdata;
		dbgValid <= 1'b0;
		// Released lines flip so a stale value never looks valid
		dbgAddr <= ~a;
		dbgWdata <= ~d;
	endtask : access
endmodule : eecs_dbg_model
`default_nettype wire

// file: dv/eeprom_command_sequencer_bench.sv
// Self-checking bench for the EEPROM command sequencer
`include "eecs_regs.svh"
`default_nettype none
module eeprom_command_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// Key value is arbitrary
	localparam logic [63:0] KEY = 64'h0F1E_2D3C_4B5A_6978;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, r;
	logic pready, pslverr, dbgResetWrite, dbgKeyWrite, dbgValid, dbgWrite, dbgReady, memoryInterfaceEnabled;
	logic [7:0] dbgResetData, dbgWdata, dbgRdata, b;
	logic [63:0] dbgKey;
	logic err;
	logic [24:0] dbgAddr;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	// Short operation wait keeps the run brief
	eecs_sequencer #(.OP_CYCLES(2), .DBG_KEY(KEY)) eecs_sequencer_i (.clk, .resetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .dbgResetWrite, .dbgResetData, .dbgKeyWrite, .dbgKey,
		.memoryInterfaceEnabled, .dbgValid, .dbgWrite, .dbgAddr, .dbgWdata, .dbgReady, .dbgRdata);
	eecs_dbg_model #(.KEY(KEY)) eecs_dbg_model_i (.clk, .dbgReady, .dbgRdata, .dbgResetWrite, .dbgResetData,
		.dbgKeyWrite, .dbgKey, .dbgValid, .dbgWrite, .dbgAddr, .dbgWdata);
	always #12.5 clk = ~clk;
	// ****
	// Shared tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic load(input logic [9:0] a, input logic [7:0] d, input logic doData);
		apb(1'b1, `EECS_OFF_ADDR_LOW, {24'h0, a[7:0]});
		apb(1'b1, `EECS_OFF_ADDR_HIGH, {30'h0, a[9:8]});
		if (doData) apb(1'b1, `EECS_OFF_DATA_LOW, {24'h0, d});
	endtask : load
	task automatic exec(input logic [6:0] cmd, input logic unlock);
		apb(1'b1, `EECS_OFF_COMMAND, {25'h0, cmd});
		if (unlock) apb(1'b1, `EECS_OFF_PROTECT, 32'h0000_00D8);
		apb(1'b1, `EECS_OFF_CONTROL_A, 32'h0000_0001);
	endtask : exec
	task automatic waitIdle(input logic expBusy);
		logic seen;
		seen = 1'b0;
		repeat (400) begin
			apb(1'b0, `EECS_OFF_STATUS, 32'h0);
			if (r[7] === 1'b1) seen = 1'b1;
			else break;
		end
		check({seen, r[7]}, {expBusy, 1'b0});
	endtask : waitIdle
	task automatic readByte(input logic [9:0] a, input logic [7:0] e);
		load(a, 8'h00, 1'b0);
		exec(`EECS_CMD_READ, 1'b1);
		apb(1'b0, `EECS_OFF_DATA_LOW, 32'h0);
		check(r[7:0], e);
		check(err, 1'b0);
	endtask : readByte
	// Page operations see only tagged bytes
	task automatic tPage();
		apb(1'b0, 12'hFFC, 32'h0);
		check(r, 32'h0000_0000);
		check(err, 1'b1);
		apb(1'b1, `EECS_OFF_COMMAND, 32'h0000_0033);
		load(10'h025, 8'hA5, 1'b1);
		load(10'h026, 8'h5A, 1'b1);
		load(10'h020, 8'h00, 1'b0);
		exec(`EECS_CMD_ERASE_WRITE_PAGE, 1'b0);
		waitIdle(1'b0);
		exec(`EECS_CMD_ERASE_WRITE_PAGE, 1'b1);
		waitIdle(1'b1);
		readByte(10'h025, 8'hA5);
		readByte(10'h026, 8'h5A);
		apb(1'b1, `EECS_OFF_COMMAND, 32'h0000_0033);
		load(10'h025, 8'h00, 1'b1);
		exec(`EECS_CMD_ERASE_PAGE, 1'b1);
		waitIdle(1'b1);
		readByte(10'h025, 8'hFF);
		readByte(10'h026, 8'h5A);
		exec(`EECS_CMD_WRITE_PAGE, 1'b1);
		waitIdle(1'b1);
		readByte(10'h025, 8'h00);
		readByte(10'h026, 8'h5A);
		exec(`EECS_CMD_ERASE_PAGE, 1'b1);
		waitIdle(1'b1);
		readByte(10'h025, 8'h00);
		apb(1'b1, `EECS_OFF_COMMAND, 32'h0000_0033);
		load(10'h005, 8'h11, 1'b1);
		exec(`EECS_CMD_ERASE_ALL, 1'b1);
		waitIdle(1'b1);
		readByte(10'h025, 8'hFF);
		readByte(10'h026, 8'h5A);
		exec(`EECS_CMD_ERASE_BUFFER, 1'b1);
		waitIdle(1'b1);
		load(10'h020, 8'h00, 1'b0);
		exec(`EECS_CMD_WRITE_PAGE, 1'b1);
		waitIdle(1'b1);
		readByte(10'h025, 8'hFF);
	endtask : tPage
	// Mapped access; a read waits out a running page write
	task automatic tDebug();
		time t;
		eecs_dbg_model_i.enable();
		repeat (50) begin
			apb(1'b0, `EECS_OFF_STATUS, 32'h0);
			if (r[0] === 1'b1) break;
		end
		check(r[0], 1'b1);
		check(memoryInterfaceEnabled, 1'b1);
		apb(1'b1, `EECS_OFF_COMMAND, 32'h0000_0033);
		eecs_dbg_model_i.access(1'b1, `EECS_EEPROM_BASE + 25'h045, 8'h3C, b);
		apb(1'b1, `EECS_OFF_COMMAND, 32'h0000_0034);
		eecs_dbg_model_i.access(1'b1, `EECS_EEPROM_BASE + 25'h040, 8'h00, b);
		t = $time;
		eecs_dbg_model_i.access(1'b0, `EECS_EEPROM_BASE + 25'h045, 8'h00, b);
		check(($time - t) > 500, 1'b1);
		check(b, 8'h00);
		apb(1'b1, `EECS_OFF_COMMAND, 32'h0000_0006);
		eecs_dbg_model_i.access(1'b0, `EECS_EEPROM_BASE + 25'h045, 8'h00, b);
		check(b, 8'h3C);
		eecs_dbg_model_i.access(1'b0, `EECS_FLASH_BASE, 8'h00, b);
		check(b, 8'h00);
	endtask : tDebug
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		tPage();
		tDebug();
		conclude();
	end
endmodule : eeprom_command_sequencer_bench
bind eecs_sequencer eecs_seq_props #(.DBG_KEY(DBG_KEY)) eecs_seq_props_i (.clk, .resetn, .psel, .penable,
	.prdata, .pready, .pslverr, .dbgResetWrite, .dbgResetData, .dbgKeyWrite, .dbgKey,
	.memoryInterfaceEnabled, .dbgValid, .dbgReady);
`default_nettype wire
